// File: rtl/fmi_top.sv
// FIFO full/watermark, any/no-motion interrupts and two interrupt pins.
// Assumes FIFO level, sample strobe and sensor events come from same-clock logic.
// Operation
// RQ1 - Full interrupt when level passes full threshold
// RQ2 - Watermark interrupt when level at or above watermark
// RQ3 - Suppress FIFO interrupts during data port read
// RQ4 - Latched FIFO bits clear on read and below
// RQ5 - Flush code resets the FIFO
// RQ6 - Automatic FIFO reset only in three cases
// RQ7 - Any-motion slope against stored reference per axis
// RQ8 - Any-motion fires after duration samples above threshold
// RQ9 - Reference reloaded only when any-motion triggers
// RQ10 - Any-motion status drops when slope falls
// RQ11 - No-motion slope between consecutive samples per axis
// RQ12 - No-motion fires after duration samples below threshold
// RQ13 - No-motion clears once slope exceeds threshold
// RQ14 - Pin drives only with its output enable
// RQ15 - Driver-type bit selects open-drain or push-pull
// RQ16 - Polarity bit selects active-high or active-low
// RQ17 - Pin input usable, loops output, edge/level
// RQ18 - Latch bit for FIFO/drdy; motion always latched
// RQ19 - Latched status clears on status read
// RQ20 - Non-latched status follows its condition
// RQ21 - Routing bit connects source to pin
// RQ22 - Host splits feature and FIFO sources
// RQ23 - Motion logic advances once per sample
//
// The register offsets and strobed register access were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module fmi_top
    import fmi_pkg::*;
(
    input  wire logic        ref_clk,        // 100 MHz clock
    input  wire logic        reset,          // Synchronous, active high
    input  wire logic [7:0]  reg_addr,       // Register byte address
    input  wire logic [31:0] reg_wdata,      // Write data
    input  wire logic        reg_wr,         // Write strobe
    input  wire logic        reg_rd,         // Read strobe
    output logic      [31:0] reg_rdata,      // Read data, cycle after strobe
    input  wire logic [10:0] fifo_level,     // FIFO fill level in bytes
    input  wire logic        fifo_reading,   // Data port read ongoing
    input  wire logic        cfg_auto_reset, // Sensor en/hdr/aux-size change
    input  wire logic        drdy_event,     // New data ready condition
    input  wire logic        sample_valid,   // New acceleration sample
    input  wire logic [15:0] acc_x,          // Signed X sample
    input  wire logic [15:0] acc_y,          // Signed Y sample
    input  wire logic [15:0] acc_z,          // Signed Z sample
    output logic             fifo_flush,     // One-cycle FIFO reset pulse
    input  wire logic        pin_a_in,       // Pin A level from pad
    output logic             pin_a_out,      // Pin A drive value
    output logic             pin_a_oe_n,     // Pin A enable, low drives
    input  wire logic        pin_b_in,       // Pin B level from pad
    output logic             pin_b_out,      // Pin B drive value
    output logic             pin_b_oe_n,     // Pin B enable, low drives
    output logic             pin_a_event,    // Input event from pin A
    output logic             pin_b_event     // Input event from pin B
);
    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    logic [7:0]  wtm_low_reg, wtm_high_reg, latch_reg;
    logic [7:0]  elec_reg [2];
    logic [7:0]  rout_reg [2];
    logic [31:0] any_cfg_reg, no_cfg_reg;
    logic [1:0]  feat_stat_reg;
    logic [2:0]  fifo_stat_reg;

    wire wr_cmd  = reg_wr && reg_addr == OFF_CMD;
    wire wr_wtml = reg_wr && reg_addr == OFF_WTM_LOW;
    wire wr_wtmh = reg_wr && reg_addr == OFF_WTM_HIGH;
    wire wr_ea   = reg_wr && reg_addr == OFF_PIN_A_ELEC;
    wire wr_eb   = reg_wr && reg_addr == OFF_PIN_B_ELEC;
    wire wr_ra   = reg_wr && reg_addr == OFF_PIN_A_ROUT;
    wire wr_rb   = reg_wr && reg_addr == OFF_PIN_B_ROUT;
    wire wr_lat  = reg_wr && reg_addr == OFF_LATCH;
    wire wr_any  = reg_wr && reg_addr == OFF_ANY_CFG;
    wire wr_no   = reg_wr && reg_addr == OFF_NO_CFG;
    wire rd_feat = reg_rd && reg_addr == OFF_STAT_FEAT;
    wire rd_fifo = reg_rd && reg_addr == OFF_STAT_FIFO;
    wire latched = latch_reg[0];

    // Any/no config: [15:0] threshold, [23:16] duration, [26:24] axis enables
    wire [15:0] any_thr = any_cfg_reg[15:0];
    wire [7:0]  any_dur = any_cfg_reg[23:16];
    wire [2:0]  any_en  = any_cfg_reg[26:24];
    wire [15:0] no_thr  = no_cfg_reg[15:0];
    wire [7:0]  no_dur  = no_cfg_reg[23:16];
    wire [2:0]  no_en   = no_cfg_reg[26:24];

    // Register writes; the watermark and routing steer the logic below
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            wtm_low_reg  <= 8'h00;
            wtm_high_reg <= 8'h00;
            latch_reg    <= 8'h00;
            elec_reg[0]  <= ELEC_RESET;
            elec_reg[1]  <= ELEC_RESET;
            rout_reg[0]  <= ROUT_RESET;
            rout_reg[1]  <= ROUT_RESET;
            any_cfg_reg  <= {8'h00, DUR_RESET, THR_RESET};
            no_cfg_reg   <= {8'h00, DUR_RESET, THR_RESET};
        end
        else
        begin
            if (wr_wtml) wtm_low_reg <= reg_wdata[7:0];
            if (wr_wtmh) wtm_high_reg <= {5'h00, reg_wdata[2:0]};
            if (wr_lat) latch_reg <= {7'h00, reg_wdata[0]};
            if (wr_ea) elec_reg[0] <= {3'h0, reg_wdata[4:0]};
            if (wr_eb) elec_reg[1] <= {3'h0, reg_wdata[4:0]};
            if (wr_ra) rout_reg[0] <= {3'h0, reg_wdata[4:0]};
            if (wr_rb) rout_reg[1] <= {3'h0, reg_wdata[4:0]};
            if (wr_any) any_cfg_reg <= {5'h00, reg_wdata[26:0]};
            if (wr_no) no_cfg_reg <= {5'h00, reg_wdata[26:0]};
        end
    end

    // ------------------------------------------------------------
    // FIFO interrupts and flush
    // ------------------------------------------------------------
    wire [10:0] wtm_level = {wtm_high_reg[2:0], wtm_low_reg};
    wire full_cond = fifo_level > FULL_THRESH && !fifo_reading;  // RQ1 RQ3
    wire wtm_cond  = fifo_level >= wtm_level && !fifo_reading;   // RQ2 RQ3
    wire full_below = fifo_level <= FULL_THRESH;
    wire wtm_below  = fifo_level < wtm_level;

    // Only the command code and the configuration-change strobe flush
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            fifo_flush <= 1'b0;
        else
            fifo_flush <= (wr_cmd && reg_wdata[7:0] == CMD_FLUSH) || cfg_auto_reset; // RQ5 RQ6
    end

    // FIFO status: bit0 drdy, bit1 full, bit2 watermark; set wins over clear
    logic [2:0] fifo_stat_next;
    always_comb
    begin
        fifo_stat_next = fifo_stat_reg;
        if (!latched)
        begin
            fifo_stat_next = {wtm_cond, full_cond, drdy_event};     // RQ18 RQ20
        end
        else
        begin
            if (rd_fifo)
            begin
                fifo_stat_next[0] = 1'b0;                           // RQ19
                if (full_below) fifo_stat_next[1] = 1'b0;           // RQ4
                if (wtm_below) fifo_stat_next[2] = 1'b0;            // RQ4
            end
            if (drdy_event) fifo_stat_next[0] = 1'b1;
            if (full_cond) fifo_stat_next[1] = 1'b1;
            if (wtm_cond) fifo_stat_next[2] = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Motion detectors
    // ------------------------------------------------------------
    logic [15:0] ref_reg [3];
    logic [15:0] prev_reg [3];
    logic [7:0]  any_cnt_reg, no_cnt_reg;
    logic        any_fire_reg;
    wire  [15:0] acc [3];
    wire  [2:0]  any_over, no_over;
    wire         any_trig;                                          // Reference update reads it
    assign acc[0] = acc_x;
    assign acc[1] = acc_y;
    assign acc[2] = acc_z;

    // Per-axis slope magnitudes against reference and previous sample
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1)
        begin : axis
            wire [15:0] d_any = acc[g] - ref_reg[g];                // RQ7
            wire [15:0] d_no  = acc[g] - prev_reg[g];               // RQ11
            wire [15:0] m_any = d_any[15] ? 16'(-d_any) : d_any;
            wire [15:0] m_no  = d_no[15] ? 16'(-d_no) : d_no;
            assign any_over[g] = any_en[g] && m_any > any_thr;
            assign no_over[g]  = no_en[g] && m_no >= no_thr;
            always_ff @(posedge ref_clk)
            begin
                if (reset)
                begin
                    ref_reg[g]  <= 16'h0000;
                    prev_reg[g] <= 16'h0000;
                end
                else if (sample_valid)                              // RQ23
                begin
                    prev_reg[g] <= acc[g];
                    if (any_trig) ref_reg[g] <= acc[g];             // RQ9
                end
            end
        end
    endgenerate

    wire any_active = |any_en;                                      // RQ7
    wire no_active  = |no_en;                                       // RQ11
    wire any_hit    = any_active && |any_over;                      // RQ8
    wire no_hit     = no_active && !(|no_over);                     // RQ12
    wire [7:0] any_cnt_inc = any_cnt_reg + 8'h01;
    wire [7:0] no_cnt_inc  = no_cnt_reg + 8'h01;
    assign any_trig = sample_valid && any_hit && any_cnt_inc >= any_dur && !any_fire_reg;
    wire no_trig  = sample_valid && no_hit && no_cnt_inc >= no_dur;

    // Consecutive-sample counters restart when the condition fails
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            any_cnt_reg  <= 8'h00;
            no_cnt_reg   <= 8'h00;
            any_fire_reg <= 1'b0;
        end
        else if (sample_valid)                                      // RQ23
        begin
            any_cnt_reg  <= any_hit ? (any_cnt_inc == 8'h00 ? 8'hFF : any_cnt_inc) : 8'h00;
            no_cnt_reg   <= no_hit ? (no_cnt_inc == 8'h00 ? 8'hFF : no_cnt_inc) : 8'h00;
            any_fire_reg <= any_trig || (any_fire_reg && any_hit);
        end
    end

    // Feature status: always latched, drops early when a sample fails the slope condition
    logic [1:0] feat_stat_next;
    always_comb
    begin
        feat_stat_next = feat_stat_reg;
        if (rd_feat) feat_stat_next = 2'b00;                        // RQ18 RQ19
        if (sample_valid && !any_hit) feat_stat_next[0] = 1'b0;     // RQ10
        if (sample_valid && !no_hit) feat_stat_next[1] = 1'b0;      // RQ13
        if (any_trig) feat_stat_next[0] = 1'b1;
        if (no_trig) feat_stat_next[1] = 1'b1;
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            feat_stat_reg <= 2'b00;
            fifo_stat_reg <= 3'b000;
        end
        else
        begin
            feat_stat_reg <= feat_stat_next;
            fifo_stat_reg <= fifo_stat_next;
        end
    end

    // ------------------------------------------------------------
    // Interrupt pins
    // ------------------------------------------------------------
    // Host is expected to keep feature and FIFO sources on separate pins
    wire [4:0] src = {fifo_stat_reg[0], fifo_stat_reg[2], fifo_stat_reg[1],
                      feat_stat_reg[1], feat_stat_reg[0]};
    wire [1:0] pin_raw = {pin_b_in, pin_a_in};
    logic [1:0] sync1_reg, sync2_reg, last_reg, drv_reg, oe_n_reg, ev_reg;
    wire  [1:0]  irq;

    generate
        for (g = 0; g < 2; g = g + 1)
        begin : pin
            wire [7:0] e = elec_reg[g];
            assign irq[g] = |(src & rout_reg[g][4:0]);              // RQ21
            // Open drain can only pull low; a high level relies on the pull-up
            wire lvl_val = e[ELEC_LVL] ? irq[g] : !irq[g];          // RQ16
            wire od_en   = e[ELEC_OD] ? !lvl_val : 1'b1;            // RQ15
            wire in_src  = e[ELEC_OUT_EN] ? irq[g] : sync2_reg[g];  // RQ17
            wire in_ev   = e[ELEC_EDGE] ? in_src && !last_reg[g] : in_src;
            always_ff @(posedge ref_clk)
            begin
                if (reset)
                begin
                    sync1_reg[g] <= 1'b0;
                    sync2_reg[g] <= 1'b0;
                    last_reg[g]  <= 1'b0;
                    drv_reg[g]   <= 1'b0;
                    oe_n_reg[g]  <= 1'b1;
                    ev_reg[g]    <= 1'b0;
                end
                else
                begin
                    sync1_reg[g] <= pin_raw[g];
                    sync2_reg[g] <= sync1_reg[g];
                    last_reg[g]  <= in_src;
                    drv_reg[g]   <= lvl_val;
                    oe_n_reg[g]  <= !(e[ELEC_OUT_EN] && od_en);     // RQ14 RQ15
                    ev_reg[g]    <= e[ELEC_IN_EN] && in_ev;         // RQ17
                end
            end
        end
    endgenerate

    assign pin_a_out   = drv_reg[0];
    assign pin_b_out   = drv_reg[1];
    assign pin_a_oe_n  = oe_n_reg[0];
    assign pin_b_oe_n  = oe_n_reg[1];
    assign pin_a_event = ev_reg[0];
    assign pin_b_event = ev_reg[1];

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    logic [31:0] rd_mux;
    always_comb
    begin
        unique case (reg_addr)
            OFF_WTM_LOW:    rd_mux = {24'h0, wtm_low_reg};
            OFF_WTM_HIGH:   rd_mux = {24'h0, wtm_high_reg};
            OFF_PIN_A_ELEC: rd_mux = {24'h0, elec_reg[0]};
            OFF_PIN_B_ELEC: rd_mux = {24'h0, elec_reg[1]};
            OFF_PIN_A_ROUT: rd_mux = {24'h0, rout_reg[0]};
            OFF_PIN_B_ROUT: rd_mux = {24'h0, rout_reg[1]};
            OFF_LATCH:      rd_mux = {24'h0, latch_reg};
            OFF_STAT_FEAT:  rd_mux = {30'h0, feat_stat_reg};
            OFF_STAT_FIFO:  rd_mux = {29'h0, fifo_stat_reg};
            OFF_ANY_CFG:    rd_mux = any_cfg_reg;
            OFF_NO_CFG:     rd_mux = no_cfg_reg;
            OFF_FIFO_LEVEL: rd_mux = {21'h0, fifo_level};
            OFF_PIN_INPUT:  rd_mux = {30'h0, sync2_reg};
            default:        rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            reg_rdata <= 32'h0000_0000;
        else
            reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    flush_cmd_a: assert property (@(posedge ref_clk) disable iff (reset) // RQ5
        wr_cmd && reg_wdata[7:0] == CMD_FLUSH |=> fifo_flush)
        else $error("flush code did not flush");
    flush_only_a: assert property (@(posedge ref_clk) disable iff (reset) // RQ6
        fifo_flush |-> $past(wr_cmd && reg_wdata[7:0] == CMD_FLUSH) || $past(cfg_auto_reset))
        else $error("flush without cause");
    supp_read_a: assert property (@(posedge ref_clk) disable iff (reset) // RQ3
        !latched && fifo_reading |=> !fifo_stat_reg[1] && !fifo_stat_reg[2])
        else $error("FIFO interrupt during read");
    wtm_follow_a: assert property (@(posedge ref_clk) disable iff (reset) // RQ20
        !latched && !fifo_reading && fifo_level >= wtm_level |=> fifo_stat_reg[2])
        else $error("watermark not shown");
    full_hold_a: assert property (@(posedge ref_clk) disable iff (reset) // RQ4
        latched && fifo_stat_reg[1] && !full_below |=> fifo_stat_reg[1])
        else $error("full status cleared above threshold");
    ref_hold_a: assert property (@(posedge ref_clk) disable iff (reset) // RQ9
        !any_trig |=> ref_reg[0] == $past(ref_reg[0]))
        else $error("reference moved without trigger");
    oe_gate_a: assert property (@(posedge ref_clk) disable iff (reset) // RQ14
        !elec_reg[0][ELEC_OUT_EN] |=> pin_a_oe_n)
        else $error("pin A driven while disabled");
    feat_read_a: assert property (@(posedge ref_clk) disable iff (reset) // RQ19
        rd_feat && !any_trig && !no_trig |=> feat_stat_reg == 2'b00)
        else $error("feature status survived read");
    no_clear_a: assert property (@(posedge ref_clk) disable iff (reset) // RQ13
        sample_valid && !no_hit |=> !feat_stat_reg[1])
        else $error("no-motion not cleared");
endmodule
`default_nettype wire

// File: rtl/fmi_pkg.sv
// Constants for the FIFO and motion interrupt block.
// Assumes a host register port with read data one cycle after the strobe.
package fmi_pkg;
    // ------------------------------------------------------------
    // Register offsets (byte addresses, word-aligned)
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_CMD        = 8'h00;
    localparam logic [7:0] OFF_WTM_LOW    = 8'h04;
    localparam logic [7:0] OFF_WTM_HIGH   = 8'h08;
    localparam logic [7:0] OFF_PIN_A_ELEC = 8'h0C;
    localparam logic [7:0] OFF_PIN_B_ELEC = 8'h10;
    localparam logic [7:0] OFF_PIN_A_ROUT = 8'h14;
    localparam logic [7:0] OFF_PIN_B_ROUT = 8'h18;
    localparam logic [7:0] OFF_LATCH      = 8'h1C;
    localparam logic [7:0] OFF_STAT_FEAT  = 8'h20;
    localparam logic [7:0] OFF_STAT_FIFO  = 8'h24;
    localparam logic [7:0] OFF_ANY_CFG    = 8'h28;
    localparam logic [7:0] OFF_NO_CFG     = 8'h2C;
    localparam logic [7:0] OFF_FIFO_LEVEL = 8'h30;
    localparam logic [7:0] OFF_PIN_INPUT  = 8'h34;
    // ------------------------------------------------------------
    // Field positions and codes
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_FLUSH      = 8'hB0;
    localparam int         ELEC_EDGE      = 0;
    localparam int         ELEC_LVL       = 1;
    localparam int         ELEC_OD        = 2;
    localparam int         ELEC_OUT_EN    = 3;
    localparam int         ELEC_IN_EN     = 4;
    localparam int         ROUT_ANY       = 0;
    localparam int         ROUT_NO        = 1;
    localparam int         ROUT_FULL      = 2;
    localparam int         ROUT_WTM       = 3;
    localparam int         ROUT_DRDY      = 4;
    localparam int         FIFO_BYTES     = 1024;
    localparam int         FRAME_BYTES    = 13;
    localparam logic [10:0] FULL_THRESH   = 11'(FIFO_BYTES - 2 * FRAME_BYTES);
    localparam logic [7:0] ELEC_RESET     = 8'h00;
    localparam logic [7:0] ROUT_RESET     = 8'h00;
    localparam logic [15:0] THR_RESET     = 16'h00AA;
    localparam logic [7:0] DUR_RESET      = 8'h05;
endpackage

// File: sim/fmi_host_pins.sv
// Host-side model of the two interrupt pin wires.
// Assumes pull-ups on both board nets, so a released pin reads high.
`timescale 1ns/100ps
`default_nettype none
module fmi_host_pins (
    input  wire logic pin_a_out,  // Pin A drive value
    input  wire logic pin_a_oe_n, // Pin A enable, low drives
    input  wire logic pin_b_out,  // Pin B drive value
    input  wire logic pin_b_oe_n, // Pin B enable, low drives
    output logic      pin_a_in,   // Resolved pin A net
    output logic      pin_b_in    // Resolved pin B net
);
    // ------------------------------------------------------------
    // Net resolution
    // ------------------------------------------------------------
    // Pull-up wins only while nobody drives; open drain depends on it
    assign pin_a_in = pin_a_oe_n ? 1'b1 : pin_a_out;
    assign pin_b_in = pin_b_oe_n ? 1'b1 : pin_b_out;
endmodule
`default_nettype wire

// File: sim/fmi_top_tb.sv
// Self-checking bench for the FIFO and motion interrupt block.
// Assumes the host pin model resolves both pin nets.
`timescale 1ns/100ps
`default_nettype none
module fmi_top_tb;
    import fmi_pkg::*;
    logic ref_clk, reset, reg_wr, reg_rd, fifo_reading, cfg_auto_reset, sample_valid;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic [10:0] fifo_level;
    logic [15:0] acc_x, acc_y;
    logic fifo_flush, pin_a_in, pin_a_out, pin_a_oe_n, pin_b_in, pin_b_out, pin_b_oe_n;
    logic drdy_event, pin_a_event, pin_b_event;
    int ev_count = 0;
    int err_total = 0;
    int compares = 0;
    fmi_top fmi_top_inst (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .fifo_level(fifo_level), .fifo_reading(fifo_reading),
        .cfg_auto_reset(cfg_auto_reset), .drdy_event(drdy_event), .sample_valid(sample_valid),
        .acc_x(acc_x), .acc_y(acc_y), .acc_z(acc_y), .fifo_flush(fifo_flush),
        .pin_a_in(pin_a_in), .pin_a_out(pin_a_out), .pin_a_oe_n(pin_a_oe_n),
        .pin_b_in(pin_b_in), .pin_b_out(pin_b_out), .pin_b_oe_n(pin_b_oe_n),
        .pin_a_event(pin_a_event), .pin_b_event(pin_b_event));
    fmi_host_pins fmi_host_pins_inst (.pin_a_out(pin_a_out), .pin_a_oe_n(pin_a_oe_n),
        .pin_b_out(pin_b_out), .pin_b_oe_n(pin_b_oe_n), .pin_a_in(pin_a_in),
        .pin_b_in(pin_b_in));
    // Count pin A events, so an edge-mode pulse can be told from a level
    always @(posedge ref_clk)
        if (pin_a_event) ev_count <= ev_count + 1;
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    // Read data are only valid in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic level(input logic [10:0] l);
        @(posedge ref_clk);
        fifo_level <= l;
        repeat (4) @(posedge ref_clk);
        #1;
    endtask
    task automatic sample(input logic [15:0] x);
        @(posedge ref_clk);
        sample_valid <= 1'b1;
        acc_x <= x;
        @(posedge ref_clk);
        sample_valid <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
    endtask
    task automatic wrap_up;
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_flush;
        logic [31:0] d;
        wr(OFF_CMD, {24'h0, CMD_FLUSH});
        #1 chk("flush", 1, fifo_flush);
        @(posedge ref_clk);
        #1 chk("flush end", 0, fifo_flush);
        @(posedge ref_clk);
        cfg_auto_reset <= 1'b1;
        @(posedge ref_clk);
        cfg_auto_reset <= 1'b0;
        #1 chk("auto flush", 1, fifo_flush);
        wr(OFF_CMD, 32'h0000_00B1);
        #1 chk("other code", 0, fifo_flush);
        rd(8'h3C, d);
        chk("unmapped", 0, d);
        $display("test flush done");
    endtask
    task automatic t_wtm;
        logic [31:0] d;
        wr(OFF_WTM_LOW, 32'h64);
        wr(OFF_WTM_HIGH, 32'h1);
        fifo_reading <= 1'b1;
        level(11'h164);
        rd(OFF_STAT_FIFO, d);
        chk("wtm reading", 0, d & 32'h4);
        fifo_reading <= 1'b0;
        level(11'h164);
        rd(OFF_STAT_FIFO, d);
        chk("wtm equal", 32'h4, d & 32'h4);
        level(11'h163);
        rd(OFF_STAT_FIFO, d);
        chk("wtm below", 0, d & 32'h4);
        drdy_event <= 1'b1;
        rd(OFF_STAT_FIFO, d);
        chk("drdy follow", 1, d & 32'h1);
        drdy_event <= 1'b0;
        rd(OFF_STAT_FIFO, d);
        chk("drdy drop", 0, d & 32'h1);
        $display("test watermark done");
    endtask
    task automatic t_full;
        logic [31:0] d;
        wr(OFF_LATCH, 32'h1);
        level(FULL_THRESH);
        rd(OFF_STAT_FIFO, d);
        chk("full at thr", 0, d & 32'h2);
        level(FULL_THRESH + 11'h1);
        rd(OFF_STAT_FIFO, d);
        chk("full above", 32'h2, d & 32'h2);
        rd(OFF_STAT_FIFO, d);
        chk("full kept", 32'h2, d & 32'h2);
        level(11'h000);
        rd(OFF_STAT_FIFO, d);
        chk("full held", 32'h2, d & 32'h2);
        rd(OFF_STAT_FIFO, d);
        chk("full clear", 0, d & 32'h6);
        wr(OFF_LATCH, 32'h0);
        $display("test full done");
    endtask
    task automatic t_pin;
        // Watermark on pin A, motion on pin B, as a latched host would split them
        wr(OFF_PIN_A_ROUT, 32'h08);
        wr(OFF_PIN_B_ROUT, 32'h03);
        wr(OFF_PIN_A_ELEC, 32'h02);
        level(11'h200);
        chk("no out_en", 1, pin_a_oe_n);
        wr(OFF_PIN_A_ELEC, 32'h0A);
        level(11'h200);
        chk("hi drive", 2'b10, {pin_a_out, pin_a_oe_n});
        wr(OFF_PIN_A_ELEC, 32'h08);
        level(11'h200);
        chk("lo drive", 2'b00, {pin_a_out, pin_a_oe_n});
        wr(OFF_PIN_A_ELEC, 32'h0C); // Active-low open drain: idle releases the net
        level(11'h000);
        chk("od release", 2'b11, {pin_a_oe_n, pin_a_in});
        level(11'h200);
        chk("od sink", 0, pin_a_in);
        wr(OFF_PIN_A_ELEC, 32'h0A);
        wr(OFF_PIN_A_ROUT, 32'h00);
        level(11'h200);
        chk("unrouted", 0, pin_a_out);
        level(11'h000);
        $display("test pins done");
    endtask
    task automatic t_in;
        logic [31:0] d;
        int n;
        wr(OFF_PIN_A_ROUT, 32'h08);
        wr(OFF_PIN_A_ELEC, 32'h1A);
        level(11'h200);
        chk("level event", 1, pin_a_event);
        chk("b no in_en", 0, pin_b_event);
        rd(OFF_PIN_INPUT, d);
        chk("pin input", 1, d & 32'h1);
        wr(OFF_PIN_A_ELEC, 32'h1B);
        level(11'h000);
        n = ev_count;
        level(11'h200);
        chk("edge once", n + 1, ev_count);
        level(11'h000);
        $display("test pin input done");
    endtask
    task automatic t_motion;
        logic [31:0] d;
        wr(OFF_PIN_B_ELEC, 32'h0A);
        wr(OFF_ANY_CFG, 32'h0102_0010);
        sample(16'h0064);
        rd(OFF_STAT_FEAT, d);
        chk("any early", 0, d & 32'h1);
        sample(16'h0064);
        chk("pin b any", 2'b10, {pin_b_out, pin_b_oe_n});
        rd(OFF_STAT_FEAT, d);
        chk("any fired", 1, d & 32'h1);
        repeat (3) sample(16'h0064);
        rd(OFF_STAT_FEAT, d);
        chk("any ref", 0, d & 32'h1);
        wr(OFF_ANY_CFG, 32'h0002_0010);
        wr(OFF_NO_CFG, 32'h0102_0010);
        acc_y <= 16'h0500; // Y and Z move, but only X is enabled
        sample(16'h0064);
        sample(16'h0064);
        sample(16'h0064);
        rd(OFF_STAT_FEAT, d);
        chk("no fired", 2, d & 32'h2);
        sample(16'h0064);
        sample(16'h012C);
        rd(OFF_STAT_FEAT, d);
        chk("no cleared", 0, d & 32'h2);
        $display("test motion done");
    endtask
    // ------------------------------------------------------------
    // Clock, reset, sequence and watchdog
    // ------------------------------------------------------------
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial
    begin
        reset = 1'b1;
        {reg_wr, reg_rd, fifo_reading, cfg_auto_reset, sample_valid, drdy_event} = 6'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        fifo_level = 11'h000;
        {acc_x, acc_y} = 32'h0;
        repeat (4) @(posedge ref_clk);
        reset <= 1'b0;
        t_flush;
        t_wtm;
        t_full;
        t_pin;
        t_in;
        t_motion;
        wrap_up;
    end
    // Tests need well under 2000 cycles
    initial
    begin
        #50000;
        err_total++;
        wrap_up;
    end
endmodule
`default_nettype wire
